// ==== hw/mcu_clk_consts.svh ====
// Purpose: offsets, field positions, reset values and timing counts of the mcu clock and reset block
// Assumes: ref_clk at 100 MHz
// Notes: Summary of operation below
//
// Summary of operation
// - Every output rate except the lowest is made by dividing the crystal oscillator and is driven on the clock pin.
// - A 3-bit select picks 30, 15, 10, 4, 3, 2, 1 MHz or 32.768 kHz for codes 000 to 111.
// - The 32.768 kHz clock comes from the internal RC oscillator or the external 32 kHz crystal, as selected.
// - After reset the clock pin carries the microcontroller clock at 4 MHz.
// - The crystal oscillator is off in sleep once any tail cycles are sent, so no crystal-derived clock exists there.
// - With the low-frequency enable set, sleep outputs 32.768 kHz whatever the select field holds.
// - In idle, transmit and receive the selected rate is output; 32.768 kHz replaces it only in sleep with the enable.
// - With the low-frequency enable clear, the clock output stops in sleep.
// - Before stopping, the clock runs 0, 128, 256 or 512 extra cycles as the 2-bit tail field says.
// - While an interrupt is pending the clock and the crystal oscillator keep running, even if sleep is commanded.
// - The microcontroller reads and clears the pending interrupt; then the commanded mode is entered.
// - A software reset request makes an internal reset pulse between 50 and 470 us long.
// - Any reset event returns every register to its default value.
// - The first general-purpose pin carries the active reset signal.
// - The second general-purpose pin carries the inverse of the reset signal.
`ifndef MCU_CLK_CONSTS_SVH
`define MCU_CLK_CONSTS_SVH

`define OPMODE_ADDR      8'h08
`define MCLK_CTRL_ADDR   8'h0a
`define STATUS_ADDR      8'h0b
`define MCLK_CTRL_RESET  8'h0b
`define OPMODE_RESET     8'h01
`define SWRST_BIT        7
`define LFSRC_BIT        2
`define MODE_LSB         0
`define TAIL_LSB         4
`define ENLFC_BIT        3
`define SEL_LSB          0

`define REF_CLK_MHZ      100
`define SWRST_MIN_US     50
`define SWRST_CYCLES     (`SWRST_MIN_US * `REF_CLK_MHZ)

`define TAIL_128         10'd128
`define TAIL_256         10'd256
`define TAIL_512         10'd512

// phase step = f_out * 2^32 / 100 MHz
`define INC_30M          32'h4ccc_cccd
`define INC_15M          32'h2666_6666
`define INC_10M          32'h1999_999a
`define INC_4M           32'h0a3d_70a4
`define INC_3M           32'h07ae_147b
`define INC_2M           32'h051e_b852
`define INC_1M           32'h028f_5c29

`endif

// ==== hw/mcu_clk_pkg.sv ====
// Purpose: types of the mcu clock and reset block
// Assumes: nothing
// Notes: none
package mcu_clk_pkg;
  typedef enum logic [1:0] {
    mode_sleep,
    mode_idle,
    mode_tx,
    mode_rx
  } op_mode_t;

  typedef enum logic [1:0] {
    st_run,
    st_tail,
    st_sleep_lf,
    st_stopped
  } clk_state_t;

  typedef struct packed {
    logic [1:0] spare;
    logic [1:0] tail;
    logic       enlfc;
    logic [2:0] sel;
  } mclk_ctrl_t;
endpackage

// ==== hw/nco_if.sv ====
// Purpose: carrier between the control logic and the crystal divider
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
interface nco_if;
  logic        run;
  logic [31:0] step;
  logic        lvl;
  logic        rise;
  modport ctrl (output run, output step, input lvl, input rise);
  modport div  (input run, input step, output lvl, output rise);
endinterface

// ==== hw/xtal_divider.sv ====
// Purpose: divides the crystal-derived rate down to the selected output frequency
// Assumes: phase accumulator, msb is the output level
// Notes: stops and clears while the oscillator is off
`timescale 1ns/1ps
module xtal_divider (
  input  wire logic ref_clk,
  input  wire logic reset,
  nco_if.div        nco
);
  logic [31:0] phase_q;
  logic [31:0] phase_d;
  logic        msb_q;
  logic        msb_d;

  always_comb begin
    phase_d = phase_q;
    if (!nco.run) begin
      phase_d = 32'h0000_0000;
    end else begin
      phase_d = phase_q + nco.step;
    end
    msb_d = phase_d[31];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_q <= 32'h0000_0000;
      msb_q   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      msb_q   <= msb_d;
    end
  end

  assign nco.lvl  = msb_q;
  assign nco.rise = msb_d & ~msb_q;
endmodule

// ==== hw/mcu_clock_and_reset_output.sv ====
// Purpose: microcontroller clock output and reset outputs of the transceiver
// Assumes: all pin inputs synchronous to ref_clk; registers reached by a plain port
// Notes: 32 kHz sources arrive as levels already sampled on ref_clk
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "mcu_clk_consts.svh"
module mcu_clock_and_reset_output #(
  parameter int SWRST_CYCLES = `SWRST_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       por_event,
  input  wire logic       low_supply,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       irq_pending,
  input  wire logic       lf_rc_clk,
  input  wire logic       lf_xtal_clk,
  output logic            clock_out_pin,
  output logic            xtal_enable,
  output logic            gpio0_reset,
  output logic            gpio1_reset_n,
  output logic            internal_reset
);
  localparam logic [12:0] SWRST_LEN = 13'(SWRST_CYCLES);

  mcu_clk_pkg::mclk_ctrl_t ctrl_q;
  mcu_clk_pkg::mclk_ctrl_t ctrl_d;
  logic [7:0]              opmode_q;
  logic [7:0]              opmode_d;
  logic [7:0]              rdata_q;
  logic [7:0]              rdata_d;
  logic [12:0]             swrst_cnt_q;
  logic [12:0]             swrst_cnt_d;
  logic                    swrst_busy;
  logic                    rst_any;
  logic                    rst_out_q;
  mcu_clk_pkg::clk_state_t state_q;
  mcu_clk_pkg::clk_state_t state_d;
  logic [9:0]              tail_cnt_q;
  logic [9:0]              tail_cnt_d;
  logic                    clk_out_q;
  logic                    clk_out_d;
  logic                    lf_lvl_q;
  logic                    lf_rise;
  logic                    lf_lvl;
  logic                    sleep_req;
  logic                    sleep_eff;
  logic                    use_lf;
  logic                    src_rise;
  logic                    src_lvl;
  logic [9:0]              tail_len;
  logic [7:0]              status;

  nco_if nco ();

  xtal_divider u_div (
    .ref_clk (ref_clk),
    .reset   (rst_any),
    .nco     (nco)
  );

  // software reset pulse; counter itself only cleared by the pin reset
  always_comb begin
    swrst_cnt_d = swrst_cnt_q;
    if (swrst_cnt_q != 13'h0000) begin
      swrst_cnt_d = swrst_cnt_q - 13'h0001;
    end else if (reg_wr && reg_addr == `OPMODE_ADDR && reg_wdata[`SWRST_BIT]) begin
      swrst_cnt_d = SWRST_LEN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      swrst_cnt_q <= 13'h0000;
    end else begin
      swrst_cnt_q <= swrst_cnt_d;
    end
  end

  assign swrst_busy = swrst_cnt_q != 13'h0000;
  assign rst_any    = reset | por_event | low_supply | swrst_busy;

  // register file and read port
  always_comb begin
    ctrl_d   = ctrl_q;
    opmode_d = opmode_q;
    rdata_d  = 8'h00;
    if (reg_wr && reg_addr == `MCLK_CTRL_ADDR) begin
      ctrl_d       = mcu_clk_pkg::mclk_ctrl_t'(reg_wdata);
      ctrl_d.spare = 2'b00;
    end
    if (reg_wr && reg_addr == `OPMODE_ADDR) begin
      opmode_d             = reg_wdata;
      opmode_d[`SWRST_BIT] = 1'b0;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `MCLK_CTRL_ADDR: rdata_d = ctrl_q;
        `OPMODE_ADDR:    rdata_d = opmode_q;
        `STATUS_ADDR:    rdata_d = status;
        default:         rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      ctrl_q   <= mcu_clk_pkg::mclk_ctrl_t'(`MCLK_CTRL_RESET);
      opmode_q <= `OPMODE_RESET;
      rdata_q  <= 8'h00;
    end else begin
      ctrl_q   <= ctrl_d;
      opmode_q <= opmode_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign status    = {4'h0, irq_pending, clk_out_q, state_q};

  // low-frequency source choice
  assign lf_lvl    = opmode_q[`LFSRC_BIT] ? lf_xtal_clk : lf_rc_clk;
  assign lf_rise   = lf_lvl & ~lf_lvl_q;
  assign use_lf    = (state_q == mcu_clk_pkg::st_sleep_lf) || (ctrl_q.sel == 3'b111);
  assign src_rise  = use_lf ? lf_rise : nco.rise;
  assign src_lvl   = use_lf ? lf_lvl : nco.lvl;

  // pending interrupt holds off sleep until the mcu clears it
  assign sleep_req = opmode_q[1:0] == 2'(mcu_clk_pkg::mode_sleep);
  assign sleep_eff = sleep_req && !irq_pending;

  always_comb begin
    unique case (ctrl_q.tail)
      2'b00:   tail_len = 10'd0;
      2'b01:   tail_len = `TAIL_128;
      2'b10:   tail_len = `TAIL_256;
      default: tail_len = `TAIL_512;
    endcase
  end

  always_comb begin
    state_d    = state_q;
    tail_cnt_d = tail_cnt_q;
    unique case (state_q)
      mcu_clk_pkg::st_run: begin
        if (sleep_eff) begin
          if (ctrl_q.enlfc) begin
            state_d = mcu_clk_pkg::st_sleep_lf;
          end else if (tail_len != 10'd0) begin
            state_d    = mcu_clk_pkg::st_tail;
            tail_cnt_d = tail_len;
          end else begin
            state_d = mcu_clk_pkg::st_stopped;
          end
        end
      end
      mcu_clk_pkg::st_tail: begin
        if (!sleep_eff) begin
          state_d = mcu_clk_pkg::st_run;
        end else if (tail_cnt_q == 10'd0) begin
          // last tail cycle reaches the pin, stop only on a low level
          if (!src_lvl) begin
            state_d = mcu_clk_pkg::st_stopped;
          end
        end else if (src_rise) begin
          tail_cnt_d = tail_cnt_q - 10'd1;
        end
      end
      mcu_clk_pkg::st_sleep_lf: begin
        if (!sleep_eff) begin
          state_d = mcu_clk_pkg::st_run;
        end
      end
      mcu_clk_pkg::st_stopped: begin
        if (!sleep_eff) begin
          state_d = mcu_clk_pkg::st_run;
        end
      end
    endcase
  end

  // clock pin level from the chosen source
  always_comb begin
    clk_out_d = 1'b0;
    if (state_q == mcu_clk_pkg::st_stopped) begin
      clk_out_d = 1'b0;
    end else if (use_lf) begin
      clk_out_d = lf_lvl;
    end else begin
      clk_out_d = nco.lvl;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst_any) begin
      state_q    <= mcu_clk_pkg::st_run;
      tail_cnt_q <= 10'd0;
      clk_out_q  <= 1'b0;
      lf_lvl_q   <= 1'b0;
      rst_out_q  <= 1'b1;
    end else begin
      state_q    <= state_d;
      tail_cnt_q <= tail_cnt_d;
      clk_out_q  <= clk_out_d;
      lf_lvl_q   <= lf_lvl;
      rst_out_q  <= 1'b0;
    end
  end

  // oscillator off in sleep once the tail is sent; selected divider step
  assign xtal_enable = (state_q == mcu_clk_pkg::st_run) || (state_q == mcu_clk_pkg::st_tail);
  assign nco.run     = xtal_enable && !rst_any;

  always_comb begin
    unique case (ctrl_q.sel)
      3'b000:  nco.step = `INC_30M;
      3'b001:  nco.step = `INC_15M;
      3'b010:  nco.step = `INC_10M;
      3'b011:  nco.step = `INC_4M;
      3'b100:  nco.step = `INC_3M;
      3'b101:  nco.step = `INC_2M;
      3'b110:  nco.step = `INC_1M;
      default: nco.step = 32'h0000_0000;
    endcase
  end

  assign clock_out_pin  = clk_out_q;
  assign gpio0_reset    = rst_out_q;
  assign gpio1_reset_n  = ~rst_out_q;
  assign internal_reset = rst_any;

  // checks
  sequence run_then_sleep_s;
    state_q == mcu_clk_pkg::st_run ##1 state_q != mcu_clk_pkg::st_run;
  endsequence

  sequence irq_hold_s;
    (irq_pending && sleep_req) [*2];
  endsequence

  sequence tail_then_stop_s;
    state_q == mcu_clk_pkg::st_tail ##1 state_q == mcu_clk_pkg::st_stopped;
  endsequence

  sleep_lf_out_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    state_q == mcu_clk_pkg::st_sleep_lf |=> clock_out_pin == $past(lf_lvl))
    else $error("sleep clock is not the low-frequency source");

  stop_low_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    state_q == mcu_clk_pkg::st_stopped |=> !clock_out_pin)
    else $error("clock pin toggles while stopped");

  xtal_sleep_off_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (state_q == mcu_clk_pkg::st_sleep_lf || state_q == mcu_clk_pkg::st_stopped) |-> !xtal_enable)
    else $error("oscillator on in sleep");

  irq_keeps_run_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (state_q == mcu_clk_pkg::st_run) and irq_hold_s |-> state_q == mcu_clk_pkg::st_run ##1 xtal_enable)
    else $error("clock left run with an interrupt pending");

  sleep_entry_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    run_then_sleep_s |-> $past(sleep_eff))
    else $error("left run without an effective sleep command");

  swrst_pulse_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(swrst_busy) |-> internal_reset [*8] ##0 swrst_cnt_q <= SWRST_LEN)
    else $error("software reset pulse too short");

  reg_default_a: assert property (@(posedge ref_clk)
    rst_any |=> ctrl_q == mcu_clk_pkg::mclk_ctrl_t'(`MCLK_CTRL_RESET) && state_q == mcu_clk_pkg::st_run)
    else $error("register not at default after reset");

  reset_pins_a: assert property (@(posedge ref_clk)
    rst_any |=> gpio0_reset && !gpio1_reset_n)
    else $error("reset pins do not show reset");

  tail_none_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (state_q == mcu_clk_pkg::st_run && sleep_eff && !ctrl_q.enlfc && ctrl_q.tail == 2'b00)
      |=> state_q == mcu_clk_pkg::st_stopped)
    else $error("tail of zero did not stop at once");

  tail_count_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (state_q == mcu_clk_pkg::st_tail && sleep_eff && !src_rise) |=> $stable(tail_cnt_q))
    else $error("tail counted without a clock edge");

  run_select_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (state_q == mcu_clk_pkg::st_run && ctrl_q.sel != 3'b111) ##1 (state_q == mcu_clk_pkg::st_run)
      |-> clock_out_pin == $past(nco.lvl))
    else $error("run clock is not the divided crystal");

  tail_hold_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (state_q == mcu_clk_pkg::st_tail && sleep_eff && tail_cnt_q == 10'd0 && src_lvl)
      |=> state_q == mcu_clk_pkg::st_tail)
    else $error("tail cut during the last high phase");

  tail_step_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (state_q == mcu_clk_pkg::st_tail && sleep_eff && tail_cnt_q != 10'd0 && src_rise)
      |=> tail_cnt_q == $past(tail_cnt_q) - 10'd1)
    else $error("tail count did not step on a clock edge");

  tail_stop_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    tail_then_stop_s |-> $past(tail_cnt_q) == 10'd0)
    else $error("tail stopped before all cycles were sent");

  wake_run_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (state_q != mcu_clk_pkg::st_run && !sleep_eff) |=> state_q == mcu_clk_pkg::st_run)
    else $error("no return to run on wake");

  no_lf_sleep_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (state_q == mcu_clk_pkg::st_run && sleep_eff && !ctrl_q.enlfc) |=> state_q != mcu_clk_pkg::st_sleep_lf)
    else $error("low-frequency sleep clock without its enable");

  irq_run_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (irq_pending && state_q == mcu_clk_pkg::st_run) |=> state_q == mcu_clk_pkg::st_run)
    else $error("run left while an interrupt is pending");

  lf_select_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (state_q == mcu_clk_pkg::st_run && ctrl_q.sel == 3'b111) |=> clock_out_pin == $past(lf_lvl))
    else $error("select 111 does not give the low-frequency clock");

  swrst_load_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(swrst_busy) |-> swrst_cnt_q == SWRST_LEN)
    else $error("software reset pulse started at the wrong length");

  pin_follow_a: assert property (@(posedge ref_clk)
    !rst_any |=> !gpio0_reset)
    else $error("reset pin held after reset ended");

  gpio_inverse_a: assert property (@(posedge ref_clk) disable iff (reset)
    gpio1_reset_n == !gpio0_reset)
    else $error("second reset pin is not the inverse");

  spare_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    ctrl_q.spare == 2'b00)
    else $error("unused control bits are set");

  rd_ctrl_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    (reg_rd && reg_addr == `MCLK_CTRL_ADDR) |=> reg_rdata == 8'($past(ctrl_q)))
    else $error("control register read back wrong");

  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (rst_any)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data stands outside its cycle");
endmodule

// ==== test/mcu_model.sv ====
// Purpose: microcontroller clocked from the block's clock pin
// Assumes: pin and irq handshake sampled on ref_clk
// Notes: counts rising edges of the received clock; owns the pending interrupt
`timescale 1ns/1ps
module mcu_model (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clock_out_pin,
  input  wire logic        irq_raise,
  input  wire logic        irq_read,
  output logic             irq_pending,
  output logic [31:0]      rise_count
);
  logic pin_q;

  always @(posedge ref_clk) begin
    pin_q <= clock_out_pin;
    if (reset) begin
      rise_count  <= 32'h0000_0000;
      irq_pending <= 1'b0;
    end else begin
      if (clock_out_pin && !pin_q) begin
        rise_count <= rise_count + 32'h0000_0001;
      end
      // reading the interrupt clears it
      if (irq_raise) begin
        irq_pending <= 1'b1;
      end else if (irq_read) begin
        irq_pending <= 1'b0;
      end
    end
  end
endmodule

// ==== test/tb_mcu_clock_and_reset_output.sv ====
// Purpose: self-checking bench of the mcu clock and reset block
// Assumes: software reset pulse shortened to 20 cycles
// Notes: rates are counted as rising edges seen by the mcu model
`timescale 1ns/1ps
module tb_mcu_clock_and_reset_output;
  localparam int SWRST = 20;
  localparam int LIMIT = 80000;
  logic        ref_clk, reset, por_event, low_supply, reg_wr, reg_rd, irq_raise, irq_read;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val;
  logic        lf_rc_clk, lf_xtal_clk, rc_run, xtal_run, irq_pending;
  logic        clock_out_pin, xtal_enable, gpio0_reset, gpio1_reset_n, internal_reset;
  logic [31:0] rise_count, mark;
  logic [10:0] lf_cnt;
  int          failures, check_count, cyc, n;
  int          khz [7] = '{30000, 15000, 10000, 4000, 3000, 2000, 1000};
  int          tails [4] = '{0, 128, 256, 512};

  mcu_clock_and_reset_output #(.SWRST_CYCLES(SWRST)) dut (
    .ref_clk(ref_clk), .reset(reset), .por_event(por_event), .low_supply(low_supply),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_pending(irq_pending), .lf_rc_clk(lf_rc_clk), .lf_xtal_clk(lf_xtal_clk),
    .clock_out_pin(clock_out_pin), .xtal_enable(xtal_enable), .gpio0_reset(gpio0_reset),
    .gpio1_reset_n(gpio1_reset_n), .internal_reset(internal_reset));

  mcu_model mcu (
    .ref_clk(ref_clk), .reset(reset), .clock_out_pin(clock_out_pin), .irq_raise(irq_raise),
    .irq_read(irq_read), .irq_pending(irq_pending), .rise_count(rise_count));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // 32.768 kHz sources, each held low while not running
  always @(posedge ref_clk) begin
    lf_cnt <= (lf_cnt == 11'h5f5) ? 11'h000 : lf_cnt + 11'h001;
    if (lf_cnt == 11'h5f5) begin
      lf_rc_clk   <= rc_run & ~lf_rc_clk;
      lf_xtal_clk <= xtal_run & ~lf_xtal_clk;
    end
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // edges counted over a window must fall within lo..hi
  task automatic rate(input string what, input int cycles, input int lo, input int hi);
    mark = rise_count;
    repeat (cycles) @(posedge ref_clk);
    #1;
    check(what, (rise_count - mark) >= lo && (rise_count - mark) <= hi, 1'b1);
  endtask

  initial begin
    reset = 1'b1;
    {por_event, low_supply, reg_wr, reg_rd, irq_raise, irq_read, xtal_run} = '0;
    {lf_rc_clk, lf_xtal_clk, rc_run} = 3'b001;
    {reg_addr, reg_wdata, lf_cnt} = '0;
    {cyc, failures, check_count} = '0;
    repeat (7) @(posedge ref_clk);
    #1;
    check("gpio0 in reset", gpio0_reset, 1'b1);
    check("gpio1 in reset", gpio1_reset_n, 1'b0);
    @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("gpio0 released", gpio0_reset, 1'b0);
    check("gpio1 released", gpio1_reset_n, 1'b1);
    rd(8'h0a, rd_val);
    check("ctrl default", rd_val, 8'h0b);
    rd(8'h3f, rd_val);
    check("unmapped read", rd_val, 8'h00);
    rate("default rate", 1000, khz[3] / 100 - 1, khz[3] / 100 + 1);
    wr(8'h0a, 8'hff);
    rd(8'h0a, rd_val);
    check("ctrl spare bits", rd_val, 8'h3f);
    $display("test defaults done");

    for (int i = 0; i < 7; i++) begin
      wr(8'h0a, 8'(i));
      repeat (20) @(posedge ref_clk);
      rate("crystal rate", 1000, khz[i] / 100 - 1, khz[i] / 100 + 1);
    end
    wr(8'h0a, 8'h07);
    rate("lf rate in run", 9000, 2, 3);
    $display("test rates done");

    wr(8'h0a, 8'h08);
    wr(8'h08, 8'h00);
    repeat (20) @(posedge ref_clk);
    #1;
    check("xtal off in sleep", xtal_enable, 1'b0);
    rd(8'h0b, rd_val);
    check("status sleep lf", rd_val & 8'h03, 8'h02);
    rate("sleep lf rc", 9000, 2, 3);
    rc_run   <= 1'b0;
    xtal_run <= 1'b1;
    wr(8'h08, 8'h04);
    repeat (3100) @(posedge ref_clk);
    rate("sleep lf crystal", 9000, 2, 3);
    wr(8'h08, 8'h01);
    repeat (20) @(posedge ref_clk);
    rate("wake rate", 1000, 299, 301);
    $display("test sleep clock done");

    for (int t = 0; t < 4; t++) begin
      wr(8'h0a, 8'(t << 4));
      repeat (20) @(posedge ref_clk);
      mark = rise_count;
      wr(8'h08, 8'h00);
      repeat (2000) @(posedge ref_clk);
      #1;
      check("tail edges", (rise_count - mark) >= tails[t] && (rise_count - mark) <= tails[t] + 2, 1'b1);
      check("pin stopped", clock_out_pin, 1'b0);
      rd(8'h0b, rd_val);
      check("status stopped", rd_val, 8'h03);
      wr(8'h08, 8'(1 + t % 3));
    end
    $display("test tail done");

    wr(8'h0a, 8'h00);
    @(posedge ref_clk);
    irq_raise <= 1'b1;
    @(posedge ref_clk);
    irq_raise <= 1'b0;
    wr(8'h08, 8'h00);
    rate("clock held by irq", 300, 89, 91);
    check("xtal held by irq", xtal_enable, 1'b1);
    @(posedge ref_clk);
    irq_read <= 1'b1;
    @(posedge ref_clk);
    irq_read <= 1'b0;
    repeat (50) @(posedge ref_clk);
    #1;
    check("sleep after irq read", xtal_enable, 1'b0);
    wr(8'h08, 8'h01);
    $display("test interrupt hold done");

    wr(8'h0a, 8'h05);
    wr(8'h08, 8'h80);
    #1;
    n = 0;
    while (internal_reset !== 1'b1 && n < 5) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    n = 0;
    while (internal_reset === 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n == 5) begin
        check("gpio0 in sw reset", gpio0_reset, 1'b1);
        check("gpio1 in sw reset", gpio1_reset_n, 1'b0);
      end
    end
    check("sw reset length", n, SWRST);
    repeat (3) @(posedge ref_clk);
    rd(8'h0a, rd_val);
    check("ctrl after sw reset", rd_val, 8'h0b);
    for (int k = 0; k < 2; k++) begin
      wr(8'h0a, 8'h05);
      @(posedge ref_clk);
      por_event  <= (k == 0);
      low_supply <= (k == 1);
      @(posedge ref_clk);
      {por_event, low_supply} <= 2'b00;
      repeat (3) @(posedge ref_clk);
      rd(8'h0a, rd_val);
      check("ctrl after reset event", rd_val, 8'h0b);
    end
    $display("test resets done");
    give_verdict();
  end
endmodule
